// >>> core/ccirq_pkg.sv
package ccirq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_UNMASK_SET = 8'h00;
  localparam logic [7:0] OFF_MASK_SET = 8'h04;
  localparam logic [7:0] OFF_UNMASK_STATE = 8'h08;
  localparam logic [7:0] OFF_PREV_DIM = 8'h0c;
  localparam logic [7:0] OFF_DOWNSCALE = 8'h10;
  localparam logic [7:0] OFF_DESC_PTR = 8'h14;
  localparam logic [7:0] OFF_CODEC_BASE = 8'h18;
  localparam logic [7:0] OFF_COEFFS_A = 8'h1c;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h20;

  // Event bit layout, shared by status, mask, enable and disable
  localparam int N_EVT = 10;
  localparam logic [N_EVT-1:0] EVT_VALID = 10'h3f7;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0] RST_DOWNSCALE = 8'h10;
  localparam logic [31:0] RST_COEFFS_A = 32'h6832_cc95;

  // Field positions and widths
  localparam int SIZE_W = 10;
  localparam int HEIGHT_LSB = 0;
  localparam int WIDTH_LSB = 16;
  localparam int DEC_W = 8;
  localparam int ALIGN_BITS = 2;

  // Limits
  localparam logic [SIZE_W:0] RGB_MAX_HEIGHT = 11'h1e0;
  localparam logic [SIZE_W:0] RGB_MAX_WIDTH = 11'h280;
  localparam logic [DEC_W-1:0] DEC_MIN = 8'h10;

  // Bit 0 is frame_start, bit 9 frame_skip_overrun
  typedef struct packed {
    logic frame_skip_overrun;
    logic codec_queue_drained;
    logic preview_queue_drained;
    logic preview_queue_overflow;
    logic codec_queue_overflow;
    logic crc_sync_error;
    logic spare;
    logic sw_reset_done_event;
    logic interface_off_event;
    logic frame_start;
  } ccirq_evt_t;

  typedef struct packed {
    logic [SIZE_W:0] width;
    logic [SIZE_W:0] height;
    logic [DEC_W-1:0] downscale_factor;
    logic no_decimation;
  } ccirq_prev_cfg_t;

  typedef struct packed {
    logic [7:0] conv_coeff_three;
    logic [7:0] conv_coeff_two;
    logic [7:0] conv_coeff_one;
    logic [7:0] conv_coeff_zero;
  } ccirq_coeffs_t;

endpackage

// >>> core/ccirq_regs.sv
`timescale 1ns/10ps
// Behaviour
// - Writing one to an enable bit unmasks that event; bits 0-2, 4-9.
// - Writing one to a disable bit masks that event, same bit layout.
// - Mask readback shows one per unmasked event, the net of enables and disables.
// - Soft-reset-done mask polarity conflicts in print; here it matches all others.
// - Preview height is field 9:0 plus one, capped at 480 for RGB.
// - Preview width is field 25:16 plus one, capped at 640 for RGB.
// - Eight-bit decimation factor; 16 or below means no decimation.
// - Descriptor write sets queue start; read returns buffer now in use.
// - Descriptor address is forced word aligned, low two bits ignored.
// - Codec base register holds a full 32-bit buffer start address.
// - Coefficient register holds four unsigned 8-bit coefficients, step 1/128.
// - Each maskable event has a status flag at the same bit position.
module ccirq_regs #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath side
  input wire ccirq_pkg::ccirq_evt_t evt,
  input wire logic rgb_mode,
  input wire logic desc_cur_upd,
  input wire logic [31:0] desc_cur_addr,
  // Configuration out
  output ccirq_pkg::ccirq_prev_cfg_t prev_cfg,
  output logic [31:0] prev_desc_start,
  output logic [31:0] codec_base,
  output ccirq_pkg::ccirq_coeffs_t coeffs,
  // Interrupt
  output logic irq
);

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
    $error("ccirq_regs: ADDR_W must be 6 to 32");
  end

  localparam int N = ccirq_pkg::N_EVT;

  logic [N-1:0] mask_reg;
  logic [N-1:0] status_reg;
  logic [31:0] dim_reg;
  logic [7:0] dec_reg;
  logic [31:0] desc_cur_reg;
  logic [31:0] desc_start_reg;
  logic [31:0] codec_reg;
  logic [31:0] coeff_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  ccirq_pkg::ccirq_prev_cfg_t cfg_reg;
  ccirq_pkg::ccirq_prev_cfg_t cfg_next;

  logic acc;
  logic ack;
  logic wr_ack;
  logic [7:0] addr;
  logic [N-1:0] wbits;
  logic [N-1:0] evt_bits;
  logic [31:0] rdata_next;
  logic decode_ok;

  assign addr = 8'(paddr);
  assign acc = psel && penable;
  // Writes land at the edge where the master samples pready high
  assign ack = acc && pready_reg;
  assign wr_ack = ack && pwrite;
  assign wbits = pwdata[N-1:0] & ccirq_pkg::EVT_VALID;
  assign evt_bits = N'(evt) & ccirq_pkg::EVT_VALID;

  // Read mux and address decode
  always_comb begin
    rdata_next = ccirq_pkg::RST_ZERO;
    decode_ok = 1'b1;
    case (addr)
      ccirq_pkg::OFF_UNMASK_SET: rdata_next = ccirq_pkg::RST_ZERO;
      ccirq_pkg::OFF_MASK_SET: rdata_next = ccirq_pkg::RST_ZERO;
      ccirq_pkg::OFF_UNMASK_STATE: rdata_next = 32'(mask_reg);
      ccirq_pkg::OFF_PREV_DIM: rdata_next = dim_reg;
      ccirq_pkg::OFF_DOWNSCALE: rdata_next = 32'(dec_reg);
      ccirq_pkg::OFF_DESC_PTR: rdata_next = desc_cur_reg;
      ccirq_pkg::OFF_CODEC_BASE: rdata_next = codec_reg;
      ccirq_pkg::OFF_COEFFS_A: rdata_next = coeff_reg;
      ccirq_pkg::OFF_EVT_STATUS: rdata_next = 32'(status_reg);
      default: decode_ok = 1'b0;
    endcase
  end

  // APB handshake: one wait state, data and error latched with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= ccirq_pkg::RST_ZERO;
    end else if (pce) begin
      if (acc && !pready_reg) begin
        pready_reg <= 1'b1;
        pslverr_reg <= !decode_ok;
        prdata_reg <= pwrite ? ccirq_pkg::RST_ZERO : rdata_next;
      end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Enable and disable writes; zero bits leave the mask alone.
  // The soft-reset-done bit uses the same set-means-unmasked sense.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= N'(ccirq_pkg::RST_ZERO);
    end else if (pce && wr_ack) begin
      if (addr == ccirq_pkg::OFF_UNMASK_SET) begin
        mask_reg <= mask_reg | wbits;
      end else if (addr == ccirq_pkg::OFF_MASK_SET) begin
        mask_reg <= mask_reg & ~wbits;
      end
    end
  end

  // Sticky event flags, write one to clear; a new event beats the clear
  for (genvar i = 0; i < N; i++) begin : g_status
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        status_reg[i] <= 1'b0;
      end else if (pce) begin
        if (evt_bits[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wr_ack && addr == ccirq_pkg::OFF_EVT_STATUS && wbits[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else if (pce) begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // Plain storage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dim_reg <= ccirq_pkg::RST_ZERO;
      dec_reg <= ccirq_pkg::RST_DOWNSCALE;
      codec_reg <= ccirq_pkg::RST_ZERO;
      coeff_reg <= ccirq_pkg::RST_COEFFS_A;
    end else if (pce && wr_ack) begin
      case (addr)
        ccirq_pkg::OFF_PREV_DIM: begin
          dim_reg <= ccirq_pkg::RST_ZERO;
          dim_reg[ccirq_pkg::HEIGHT_LSB +: ccirq_pkg::SIZE_W] <=
            pwdata[ccirq_pkg::HEIGHT_LSB +: ccirq_pkg::SIZE_W];
          dim_reg[ccirq_pkg::WIDTH_LSB +: ccirq_pkg::SIZE_W] <=
            pwdata[ccirq_pkg::WIDTH_LSB +: ccirq_pkg::SIZE_W];
        end
        ccirq_pkg::OFF_DOWNSCALE: dec_reg <= pwdata[ccirq_pkg::DEC_W-1:0];
        ccirq_pkg::OFF_CODEC_BASE: codec_reg <= pwdata;
        ccirq_pkg::OFF_COEFFS_A: coeff_reg <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // Descriptor: software sets the queue start, the datapath moves the
  // current pointer. A software write wins over a same-cycle update.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_start_reg <= ccirq_pkg::RST_ZERO;
      desc_cur_reg <= ccirq_pkg::RST_ZERO;
    end else if (pce) begin
      if (wr_ack && addr == ccirq_pkg::OFF_DESC_PTR) begin
        desc_start_reg <= {pwdata[31:ccirq_pkg::ALIGN_BITS],
                           ccirq_pkg::ALIGN_BITS'(0)};
        desc_cur_reg <= {pwdata[31:ccirq_pkg::ALIGN_BITS],
                         ccirq_pkg::ALIGN_BITS'(0)};
      end else if (desc_cur_upd) begin
        desc_cur_reg <= {desc_cur_addr[31:ccirq_pkg::ALIGN_BITS],
                         ccirq_pkg::ALIGN_BITS'(0)};
      end
    end
  end

  // Preview geometry; caps apply only while the datapath runs RGB
  always_comb begin
    cfg_next.height = (ccirq_pkg::SIZE_W + 1)'(dim_reg[ccirq_pkg::HEIGHT_LSB +:
                       ccirq_pkg::SIZE_W]) + 11'h001;
    cfg_next.width = (ccirq_pkg::SIZE_W + 1)'(dim_reg[ccirq_pkg::WIDTH_LSB +:
                      ccirq_pkg::SIZE_W]) + 11'h001;
    if (rgb_mode && cfg_next.height > ccirq_pkg::RGB_MAX_HEIGHT) begin
      cfg_next.height = ccirq_pkg::RGB_MAX_HEIGHT;
    end
    if (rgb_mode && cfg_next.width > ccirq_pkg::RGB_MAX_WIDTH) begin
      cfg_next.width = ccirq_pkg::RGB_MAX_WIDTH;
    end
    cfg_next.downscale_factor = dec_reg;
    cfg_next.no_decimation = (dec_reg <= ccirq_pkg::DEC_MIN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '0;
    end else if (pce) begin
      cfg_reg <= cfg_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign prev_cfg = cfg_reg;
  assign prev_desc_start = desc_start_reg;
  assign codec_base = codec_reg;
  assign coeffs = coeff_reg;

  property p_unmask;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_ack && addr == ccirq_pkg::OFF_UNMASK_SET) |=>
      ((mask_reg & $past(wbits)) == $past(wbits)) &&
      ((mask_reg & ~$past(wbits)) == ($past(mask_reg) & ~$past(wbits)));
  endproperty
  a_unmask: assert property (p_unmask) else $error("enable write failed");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_ack && addr == ccirq_pkg::OFF_MASK_SET) |=>
      ((mask_reg & $past(wbits)) == '0) &&
      ((mask_reg & ~$past(wbits)) == ($past(mask_reg) & ~$past(wbits)));
  endproperty
  a_mask: assert property (p_mask) else $error("disable write failed");

  property p_mask_read;
    @(posedge pclk) disable iff (!presetn)
    (pce && acc && !pready_reg && !pwrite && addr == ccirq_pkg::OFF_UNMASK_STATE) |=>
      pready && prdata == 32'($past(mask_reg));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");

  // A clear may remove the flag in the same edge, so irq follows the old product
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    pce |=> irq == $past(|(status_reg & mask_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_evt_set;
    @(posedge pclk) disable iff (!presetn)
    (pce && evt_bits != '0) |=> ((status_reg & $past(evt_bits)) == $past(evt_bits));
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event flag lost");

  property p_rgb_cap;
    @(posedge pclk) disable iff (!presetn)
    (pce && rgb_mode) |=> prev_cfg.height <= ccirq_pkg::RGB_MAX_HEIGHT &&
      prev_cfg.width <= ccirq_pkg::RGB_MAX_WIDTH &&
      prev_cfg.height != '0;
  endproperty
  a_rgb_cap: assert property (p_rgb_cap) else $error("preview size over cap");

  property p_no_dec;
    @(posedge pclk) disable iff (!presetn)
    pce |=> prev_cfg.no_decimation == ($past(dec_reg) <= ccirq_pkg::DEC_MIN);
  endproperty
  a_no_dec: assert property (p_no_dec) else $error("decimation flag wrong");

  property p_align;
    @(posedge pclk) disable iff (!presetn)
    desc_cur_reg[ccirq_pkg::ALIGN_BITS-1:0] == '0 &&
      prev_desc_start[ccirq_pkg::ALIGN_BITS-1:0] == '0;
  endproperty
  a_align: assert property (p_align) else $error("descriptor not aligned");

  property p_codec;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_ack && addr == ccirq_pkg::OFF_CODEC_BASE) |=> codec_base == $past(pwdata);
  endproperty
  a_codec: assert property (p_codec) else $error("codec base not stored");

  property p_status_clr;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_ack && addr == ccirq_pkg::OFF_EVT_STATUS) |=>
      (status_reg & $past(wbits & ~evt_bits)) == '0;
  endproperty
  a_status_clr: assert property (p_status_clr) else $error("status clear failed");

  property p_stat_read;
    @(posedge pclk) disable iff (!presetn)
    (pce && acc && !pready_reg && !pwrite && addr == ccirq_pkg::OFF_EVT_STATUS) |=>
      prdata == 32'($past(status_reg));
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status readback wrong");

  property p_desc_wr;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_ack && addr == ccirq_pkg::OFF_DESC_PTR) |=>
      prev_desc_start[31:ccirq_pkg::ALIGN_BITS] == $past(pwdata[31:ccirq_pkg::ALIGN_BITS]) &&
      desc_cur_reg == prev_desc_start;
  endproperty
  a_desc_wr: assert property (p_desc_wr) else $error("descriptor write lost");

  property p_desc_upd;
    @(posedge pclk) disable iff (!presetn)
    (pce && desc_cur_upd && !(wr_ack && addr == ccirq_pkg::OFF_DESC_PTR)) |=>
      desc_cur_reg[31:ccirq_pkg::ALIGN_BITS] ==
        $past(desc_cur_addr[31:ccirq_pkg::ALIGN_BITS]);
  endproperty
  a_desc_upd: assert property (p_desc_upd) else $error("current pointer not moved");

  property p_coeff;
    @(posedge pclk) disable iff (!presetn)
    (pce && wr_ack && addr == ccirq_pkg::OFF_COEFFS_A) |=> coeffs == $past(pwdata);
  endproperty
  a_coeff: assert property (p_coeff) else $error("coefficients not stored");

  property p_geom;
    @(posedge pclk) disable iff (!presetn)
    (pce && !rgb_mode) |=>
      prev_cfg.height ==
        {1'b0, $past(dim_reg[ccirq_pkg::HEIGHT_LSB +: ccirq_pkg::SIZE_W])} + 11'h001 &&
      prev_cfg.width ==
        {1'b0, $past(dim_reg[ccirq_pkg::WIDTH_LSB +: ccirq_pkg::SIZE_W])} + 11'h001;
  endproperty
  a_geom: assert property (p_geom) else $error("preview size wrong");

  // Clock enable low must hold every flag, pointer and bus answer
  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
    !pce |=> $stable(mask_reg) && $stable(status_reg) && $stable(irq) &&
      $stable(prev_cfg) && $stable(desc_cur_reg) && $stable(pready);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule

// >>> test/ccirq_tb.sv
`timescale 1ns/10ps
module tb;
  logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, rgb_mode, irq;
  logic desc_cur_upd, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, desc_cur_addr, prev_desc_start, codec_base, rd;
  logic [10:0] ew, eh;
  ccirq_pkg::ccirq_evt_t evt;
  ccirq_pkg::ccirq_prev_cfg_t prev_cfg;
  ccirq_pkg::ccirq_coeffs_t coeffs;
  int fails, compares;
  logic [31:0] dw[4] = '{32'hffff_ffff, 32'h0100_0050, 32'h027f_01df, 32'h0280_01e0};
  logic [7:0] dv[4] = '{8'h00, 8'h10, 8'h11, 8'hff};
  // Written out here so a wrong event layout in the package cannot hide itself
  localparam logic [9:0] VALID = 10'h3f7;

  ccirq_regs #(.ADDR_W(8)) dut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .rgb_mode(rgb_mode), .desc_cur_upd(desc_cur_upd),
    .desc_cur_addr(desc_cur_addr), .prev_cfg(prev_cfg), .prev_desc_start(prev_desc_start),
    .codec_base(codec_base), .coeffs(coeffs), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One idle edge after each transfer keeps psel from being driven twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evt = '0;
    rgb_mode = 1'b0;
    desc_cur_upd = 1'b0;
    desc_cur_addr = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ccirq_pkg::OFF_UNMASK_STATE, 32'h0);
    rdc(ccirq_pkg::OFF_PREV_DIM, 32'h0);
    rdc(ccirq_pkg::OFF_DOWNSCALE, 32'h10);
    rdc(ccirq_pkg::OFF_DESC_PTR, 32'h0);
    rdc(ccirq_pkg::OFF_CODEC_BASE, 32'h0);
    rdc(ccirq_pkg::OFF_COEFFS_A, 32'h6832_cc95);
    chk(err, 1'b0);
    chk(coeffs, 32'h6832_cc95);
    $display("test reset values done");
    wr(ccirq_pkg::OFF_UNMASK_SET, 32'hffff_ffff);
    rdc(ccirq_pkg::OFF_UNMASK_STATE, 32'h3f7);
    wr(ccirq_pkg::OFF_MASK_SET, 32'h0);
    rdc(ccirq_pkg::OFF_UNMASK_STATE, 32'h3f7);
    wr(ccirq_pkg::OFF_MASK_SET, 32'h204);
    rdc(ccirq_pkg::OFF_UNMASK_STATE, 32'h1f3);
    wr(ccirq_pkg::OFF_UNMASK_SET, 32'h0);
    wr(ccirq_pkg::OFF_UNMASK_STATE, 32'h0);
    rdc(ccirq_pkg::OFF_UNMASK_STATE, 32'h1f3);
    rdc(ccirq_pkg::OFF_UNMASK_SET, 32'h0);
    rdc(ccirq_pkg::OFF_MASK_SET, 32'h0);
    $display("test masks done");
    for (int i = 0; i < 10; i++) begin
      wr(ccirq_pkg::OFF_MASK_SET, 32'h3ff);
      evt <= ccirq_pkg::ccirq_evt_t'(10'h1 << i);
      @(posedge pclk);
      evt <= '0;
      repeat (3) @(posedge pclk);
      chk(irq, 1'b0);
      wr(ccirq_pkg::OFF_UNMASK_SET, 32'h1 << i);
      repeat (2) @(posedge pclk);
      chk(irq, VALID[i]);
      rdc(ccirq_pkg::OFF_EVT_STATUS, {22'h0, VALID & (10'h1 << i)});
      wr(ccirq_pkg::OFF_EVT_STATUS, 32'h3ff);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
    end
    $display("test events done");
    for (int k = 0; k < 4; k++) begin
      wr(ccirq_pkg::OFF_PREV_DIM, dw[k]);
      rdc(ccirq_pkg::OFF_PREV_DIM, dw[k] & 32'h03ff_03ff);
      for (int j = 0; j < 2; j++) begin
        rgb_mode <= j[0];
        repeat (2) @(posedge pclk);
        ew = {1'b0, dw[k][25:16]} + 11'd1;
        eh = {1'b0, dw[k][9:0]} + 11'd1;
        if (j == 1 && ew > 11'd640) ew = 11'd640;
        if (j == 1 && eh > 11'd480) eh = 11'd480;
        chk(prev_cfg.width, ew);
        chk(prev_cfg.height, eh);
      end
    end
    $display("test dimensions done");
    for (int k = 0; k < 4; k++) begin
      wr(ccirq_pkg::OFF_DOWNSCALE, {24'hffffff, dv[k]});
      rdc(ccirq_pkg::OFF_DOWNSCALE, {24'h0, dv[k]});
      repeat (2) @(posedge pclk);
      chk(prev_cfg.downscale_factor, dv[k]);
      chk(prev_cfg.no_decimation, dv[k] <= 8'h10);
    end
    $display("test downscale done");
    wr(ccirq_pkg::OFF_DESC_PTR, 32'h1234_5677);
    rdc(ccirq_pkg::OFF_DESC_PTR, 32'h1234_5674);
    desc_cur_addr <= 32'habcd_0003;
    desc_cur_upd <= 1'b1;
    @(posedge pclk);
    desc_cur_upd <= 1'b0;
    desc_cur_addr <= 32'h5555_5555;
    rdc(ccirq_pkg::OFF_DESC_PTR, 32'habcd_0000);
    chk(prev_desc_start, 32'h1234_5674);
    // With the clock enable low an event and a pointer update must both be ignored
    pce <= 1'b0;
    evt <= ccirq_pkg::ccirq_evt_t'(10'h001);
    desc_cur_upd <= 1'b1;
    repeat (3) @(posedge pclk);
    evt <= '0;
    desc_cur_upd <= 1'b0;
    pce <= 1'b1;
    @(posedge pclk);
    rdc(ccirq_pkg::OFF_DESC_PTR, 32'habcd_0000);
    rdc(ccirq_pkg::OFF_EVT_STATUS, 32'h0);
    $display("test clock enable done");
    wr(ccirq_pkg::OFF_CODEC_BASE, 32'hdead_beef);
    rdc(ccirq_pkg::OFF_CODEC_BASE, 32'hdead_beef);
    chk(codec_base, 32'hdead_beef);
    wr(ccirq_pkg::OFF_COEFFS_A, 32'h0180_ff7f);
    rdc(ccirq_pkg::OFF_COEFFS_A, 32'h0180_ff7f);
    chk(coeffs.conv_coeff_three, 8'h01);
    chk(coeffs.conv_coeff_zero, 8'h7f);
    $display("test data registers done");
    wr(8'h24, 32'h1);
    chk(err, 1'b1);
    rdc(8'hfc, 32'h0);
    chk(err, 1'b1);
    // Reset in mid-run must drop every register, not only the first-time state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ccirq_pkg::OFF_CODEC_BASE, 32'h0);
    rdc(ccirq_pkg::OFF_UNMASK_STATE, 32'h0);
    $display("test unmapped and reset done");
    stop_test();
  end
endmodule
